// ---- common/mst_pkg.sv ----
package mst_pkg;
	localparam int APB_AW = 8;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_MMAP = 8'h0C;
	localparam logic [7:0] REG_THR0 = 8'h10;
	localparam logic [7:0] REG_THR1 = 8'h14;
	localparam logic [7:0] REG_THR2 = 8'h18;
	localparam logic [7:0] REG_MOUT = 8'h1C;
	localparam logic [7:0] REG_IOUT = 8'h20;
	// control fields
	localparam int CTRL_ANALOG = 2;
	localparam int CTRL_CLRALM = 0;
	// command register fields
	localparam int CMD_M_LSB = 0;
	localparam int CMD_S_LSB = 8;
	localparam int CMD_T_LSB = 24;
	localparam int CMD_HAS_M = 28;
	localparam int CMD_HAS_S = 29;
	localparam int CMD_HAS_T = 30;
	localparam int CMD_MOTION = 31;
	// m code map entry: valid, bit index 0..63 (64 register bits)
	localparam int MMAP_VALID = 15;
	localparam int MMAP_ENTRIES = 100;
	localparam logic [6:0] M_STOP = 7'h00;
	localparam logic [6:0] M_OPT = 7'h01;
	localparam logic [6:0] M_END = 7'h02;
	localparam logic [6:0] M_REW = 7'h1E;
	localparam logic [6:0] M_SUBCALL = 7'h62;
	localparam logic [6:0] M_SUBRET = 7'h63;
	localparam logic [6:0] M_BIN_MAX = 7'h27;
	localparam logic [15:0] THR0_RST = 16'h03E8;
	localparam logic [15:0] THR1_RST = 16'h07D0;
	localparam logic [15:0] THR2_RST = 16'h0FA0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	typedef struct packed {
		logic m_code_strobe;
		logic s_code_strobe;
		logic tool_code_strobe;
	} mst_strobe_s;

	typedef struct packed {
		logic all_functions_done;
		logic m_function_done;
		logic s_function_done;
		logic t_function_done;
		logic m_acknowledge;
		logic s_acknowledge;
		logic gear_shift_done;
	} mst_plc_in_s;

	typedef struct packed {
		logic decoded_program_stop;
		logic decoded_optional_stop;
		logic decoded_program_end;
		logic decoded_end_rewind;
	} mst_dec_s;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_M = 7'b0000010,
		ST_S = 7'b0000100,
		ST_T = 7'b0001000,
		ST_WAIT_DONE = 7'b0010000,
		ST_WAIT_LOW = 7'b0100000,
		ST_ALARM = 7'b1000000
	} mst_state_e;
endpackage : mst_pkg

// ---- verification/mst_function_handshake_monitor.sv ----
`timescale 1ns/1ps
module mst_function_handshake_monitor (
	// clocking
	input wire logic ref_clk,
	input wire logic resetn,
	// plc side
	input wire mst_pkg::mst_plc_in_s plc_in,
	input wire mst_pkg::mst_strobe_s strobe,
	input wire logic [63:0] m_reg_bits,
	input wire logic [7:0] m_binary,
	input wire logic [7:0] decoded_byte,
	input wire logic [7:0] gear_addr,
	input wire logic [2:0] gear_step,
	input wire logic [7:0] tool_word,
	input wire logic block_done,
	input wire logic alarm
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic done_seen;
	logic next_done_seen;
	logic issued;
	logic next_issued;
	// all done and strobes seen since the last block end or alarm
	always_comb begin
		next_done_seen = done_seen | plc_in.all_functions_done;
		next_issued = issued | (strobe != 3'h0);
		if (!resetn || block_done || alarm) begin
			next_done_seen = 1'h0;
			next_issued = 1'h0;
		end
	end
	always_ff @(posedge ref_clk) begin
		done_seen <= next_done_seen;
		issued <= next_issued;
	end
	m_bits_a: assert property ($rose(strobe.m_code_strobe) |->
		$onehot(m_reg_bits)) else $error("m bits");
	alarm_quiet_a: assert property ($rose(alarm) |=> strobe == 3'h0)
		else $error("alarm strobe");
	done_gate_a: assert property (block_done && issued |-> done_seen)
		else $error("early block end");
	s_step_a: assert property ($rose(strobe.s_code_strobe) |->
		$onehot({gear_addr, gear_step})) else $error("s bits");
	tool_word_a: assert property (tool_word != 8'h00 |->
		strobe.tool_code_strobe) else $error("tool word");
	dec_clear_a: assert property (plc_in.all_functions_done [*4] |=>
		decoded_byte == 8'h00) else $error("decoded kept");
	done_drop_a: assert property (plc_in.all_functions_done [*4] |=>
		strobe == 3'h0 && gear_addr == 8'h00) else $error("strobe kept");
	dec_place_a: assert property (decoded_byte != 8'h00 |->
		decoded_byte[3:0] == 4'h0 && $onehot(decoded_byte))
		else $error("decoded place");
	dec_rewind_a: assert property (decoded_byte[4] |->
		m_binary == 8'h1E && strobe.m_code_strobe) else $error("rewind");
	m_issue_c: cover property ($rose(strobe.m_code_strobe));
	blk_end_c: cover property (block_done);
	alarm_c: cover property ($rose(alarm));
endmodule : mst_function_handshake_monitor
bind mst_function_handshake mst_function_handshake_monitor u_mon (.ref_clk,
	.resetn, .plc_in, .strobe, .m_reg_bits, .m_binary, .decoded_byte,
	.gear_addr, .gear_step, .tool_word, .block_done, .alarm);

// ---- verification/mst_function_handshake_test.sv ----
`timescale 1ns/1ps
module mst_function_handshake_test;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic block_done, alarm, err;
	logic [7:0] paddr, m_binary, decoded_byte, gear_addr, tool_word, dly;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] m_reg_bits;
	logic [2:0] gear_step;
	mst_pkg::mst_plc_in_s plc_in;
	mst_pkg::mst_strobe_s strobe;
	int error_cnt = 0;
	int compares = 0;

	mst_function_handshake u_dut (.ref_clk, .resetn, .clk_en(1'h1), .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.plc_in, .strobe, .m_reg_bits, .m_binary, .decoded_byte, .gear_addr,
		.gear_step, .tool_word, .block_done, .alarm);
	mst_plc_model u_plc (.ref_clk, .resetn, .strobe, .delay(dly), .plc_in);

	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	task chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task give_verdict;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50) begin
			chk(1'h0, 1'h1);
			give_verdict();
		end
	endtask : apb

	// k 0 waits for block end, 1 for alarm, 2..4 for a strobe
	task wait_for(input int k);
		int n;
		n = 0;
		while ((k == 0 ? block_done : k == 1 ? alarm : strobe[k - 2]) !== 1'h1
			&& n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 200) begin
			chk(1'h0, 1'h1);
			give_verdict();
		end
	endtask : wait_for

	task map(input logic [6:0] code, input logic [5:0] idx);
		apb(1'h1, mst_pkg::REG_MMAP, {16'h0000, 1'h1, code, 2'h0, idx});
	endtask : map

	task t_regs;
		apb(1'h0, mst_pkg::REG_THR0, 32'h0);
		chk(rd, {16'h0000, mst_pkg::THR0_RST});
		apb(1'h0, mst_pkg::REG_CTRL, 32'h0);
		chk(rd, mst_pkg::CTRL_RST);
		apb(1'h0, mst_pkg::REG_STAT, 32'h0);
		chk(rd, 32'h0000_0200);
		apb(1'h0, 8'h3C, 32'h0);
		chk({err, rd}, {1'h1, 32'h0});
		$display("test regs done");
	endtask : t_regs

	task t_mst;
		dly <= 8'h0C;
		map(7'h03, 6'h05);
		apb(1'h1, mst_pkg::REG_CMD, 32'hF900_0503);
		wait_for(4);
		chk(strobe, 3'h4);
		chk(m_reg_bits, 64'h20);
		chk(m_binary, 8'h03);
		@(posedge ref_clk);
		chk(strobe, 3'h6);
		chk(gear_addr, 8'h10);
		@(posedge ref_clk);
		chk(strobe, 3'h7);
		chk(tool_word, 8'h09);
		wait_for(0);
		chk({strobe, gear_addr, tool_word, m_binary}, 27'h0);
		chk(m_reg_bits, 64'h0);
		$display("test mst done");
	endtask : t_mst

	task t_dec;
		logic [6:0] code [4] = '{mst_pkg::M_STOP, mst_pkg::M_OPT,
			mst_pkg::M_END, mst_pkg::M_REW};
		dly <= 8'h00;
		for (int i = 0; i < 4; i++) begin
			map(code[i], 6'(60 + i));
			apb(1'h1, mst_pkg::REG_CMD, 32'h1000_0000 | 32'(code[i]));
			wait_for(4);
			chk(decoded_byte, 8'h80 >> i);
			chk(m_binary, 8'(code[i]));
			chk(m_reg_bits, 64'h1 << (60 + i));
			wait_for(0);
			chk(decoded_byte, 8'h00);
		end
		$display("test decoded done");
	endtask : t_dec

	task t_alarm;
		logic [31:0] bad [2] = '{32'h1000_0007, 32'h2000_0900};
		for (int i = 0; i < 2; i++) begin
			apb(1'h1, mst_pkg::REG_CMD, bad[i]);
			wait_for(1);
			chk({strobe, gear_addr}, 11'h0);
			apb(1'h1, mst_pkg::REG_CTRL, 32'h1);
			@(posedge ref_clk);
			chk(alarm, 1'h0);
		end
		$display("test alarm done");
	endtask : t_alarm

	task t_analog;
		logic [15:0] spd [3] = '{16'h03E8, 16'h03E9, 16'h0FA1};
		apb(1'h1, mst_pkg::REG_CTRL, 32'h4);
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, mst_pkg::REG_CMD, {8'h20, spd[i], 8'h00});
			wait_for(3);
			chk({gear_step, gear_addr}, {3'h1 << i, 8'h00});
			wait_for(0);
		end
		apb(1'h1, mst_pkg::REG_CTRL, 32'h0);
		$display("test analog done");
	endtask : t_analog

	task t_sub;
		logic [6:0] sub [2] = '{mst_pkg::M_SUBCALL, mst_pkg::M_SUBRET};
		logic got_done;
		for (int i = 0; i < 2; i++) begin
			got_done = 1'h0;
			map(sub[i], 6'h09);
			apb(1'h1, mst_pkg::REG_CMD, 32'h1000_0000 | 32'(sub[i]));
			repeat (6) begin
				@(posedge ref_clk);
				got_done = got_done | block_done;
				chk(strobe, 3'h0);
				chk(m_reg_bits, 64'h0);
			end
			chk(got_done, 1'h1);
		end
		$display("test subprogram done");
	endtask : t_sub

	initial begin
		resetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dly = 8'h00;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'h1;
		t_regs();
		t_mst();
		t_dec();
		t_alarm();
		t_analog();
		t_sub();
		give_verdict();
	end
endmodule : mst_function_handshake_test

// ---- verification/mst_plc_model.sv ----
`timescale 1ns/1ps
module mst_plc_model (
	// clocking
	input wire logic ref_clk,
	input wire logic resetn,
	// device side
	input wire mst_pkg::mst_strobe_s strobe,
	input wire logic [7:0] delay,
	output mst_pkg::mst_plc_in_s plc_in
);
	logic [7:0] cnt;
	mst_pkg::mst_strobe_s seen;
	always @(posedge ref_clk) begin
		if (!resetn || strobe == 3'h0) begin
			plc_in <= '0;
			seen <= '0;
			cnt <= 8'h00;
		end else if (strobe != seen) begin
			// a new class restarts the work time
			seen <= strobe;
			cnt <= 8'h00;
		end else if (cnt < delay) begin
			cnt <= cnt + 8'h01;
		end else begin
			plc_in.m_acknowledge <= seen.m_code_strobe;
			plc_in.m_function_done <= seen.m_code_strobe;
			plc_in.s_acknowledge <= seen.s_code_strobe;
			plc_in.s_function_done <= seen.s_code_strobe;
			plc_in.gear_shift_done <= seen.s_code_strobe;
			plc_in.t_function_done <= seen.tool_code_strobe;
			plc_in.all_functions_done <= 1'h1;
		end
	end
endmodule : mst_plc_model

// ---- verilog/mst_function_handshake.sv ----
`timescale 1ns/1ps
// Behaviour
// [RULE_01] on an m code, drive its mapped register bit and m strobe together
// [RULE_02] alarm when a called m code has no register bit mapped
// [RULE_03] functions are issued while block motion or dwell proceeds
// [RULE_04] several functions in one block issue one after another
// [RULE_05] next block starts only after all-done input seen high
// [RULE_06] plc raises m done and all done after the m operation
// [RULE_07] plc holds all done low until every concurrent function ends
// [RULE_08] plc holds m acknowledge low during execution, high on completion
// [RULE_09] one control bit selects gear or analog spindle handling
// [RULE_10] gear mode takes S1..S8 onto gear bits 0..7, alarms otherwise
// [RULE_11] gear mode drives gear bit and s strobe together
// [RULE_12] plc handles s acknowledge, s done and all done likewise
// [RULE_13] analog mode picks a gear step from speed and three thresholds
// [RULE_14] analog mode drives the step bit and s strobe together
// [RULE_15] plc raises gear shift done after the gear change
// [RULE_16] a tool code places its number on the tool word with strobe
// [RULE_17] plc raises tool done and all done after the tool operation
// [RULE_18] subprogram and macro call codes are handled inside, never output
// [RULE_19] stop, optional stop, end and rewind codes add a decoded signal
// [RULE_20] m codes 0 to 39 are also given as a binary value
// [RULE_21] decoded signals sit on bits 7,6,5,4 of one byte
// [RULE_22] decoded signals clear on all done high or on reset
// [RULE_23] after all done, drop strobes and codes, wait for all done low
module mst_function_handshake (
	// clocking
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// plc answers (pins)
	input wire mst_pkg::mst_plc_in_s plc_in,
	// plc outputs
	output mst_pkg::mst_strobe_s strobe,
	output logic [63:0] m_reg_bits,
	output logic [7:0] m_binary,
	output logic [7:0] decoded_byte,
	output logic [7:0] gear_addr,
	output logic [2:0] gear_step,
	output logic [7:0] tool_word,
	// sequencer status
	output logic block_done,
	output logic alarm
);
	mst_pkg::mst_plc_in_s plc_s;
	mst_pkg::mst_state_e state, next_state;
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] cmd, next_cmd;
	logic [6:0] map_idx [mst_pkg::MMAP_ENTRIES];
	logic map_vld [mst_pkg::MMAP_ENTRIES];
	logic has_m, has_s, has_t, next_has_m, next_has_s, next_has_t;
	logic [2:0] step_c;
	logic next_alarm, next_block_done;
	mst_pkg::mst_strobe_s next_strobe;
	logic [63:0] next_m_reg_bits;
	logic [7:0] next_m_binary, next_decoded, next_gear_addr, next_tool_word;
	logic [2:0] next_gear_step;
	logic [15:0] thr0, thr1, thr2, next_thr0, next_thr1, next_thr2;
	logic wr, rd;
	logic [6:0] mcode;
	logic [15:0] scode;

	function automatic logic mapped_addr(input logic [7:0] a);
		mapped_addr = (a == mst_pkg::REG_CTRL) || (a == mst_pkg::REG_CMD) ||
			(a == mst_pkg::REG_STAT) || (a == mst_pkg::REG_MMAP) ||
			(a == mst_pkg::REG_THR0) || (a == mst_pkg::REG_THR1) ||
			(a == mst_pkg::REG_THR2) || (a == mst_pkg::REG_MOUT) ||
			(a == mst_pkg::REG_IOUT);
	endfunction : mapped_addr

	mst_sync #(.W(7)) u_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.d(plc_in),
		.q(plc_s)
	);

	mst_gear_step u_step (
		.speed(scode),
		.thr0(thr0),
		.thr1(thr1),
		.thr2(thr2),
		.step(step_c)
	); // [RULE_13]

	assign wr = psel && penable && pwrite && clk_en;
	assign rd = psel && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped_addr(paddr);
	assign mcode = cmd[mst_pkg::CMD_M_LSB +: 7];
	assign scode = cmd[mst_pkg::CMD_S_LSB +: 16];

	always_comb begin
		prdata = 32'h0000_0000;
		if (rd) begin
			case (paddr)
				mst_pkg::REG_CTRL: prdata = ctrl;
				mst_pkg::REG_CMD: prdata = cmd;
				mst_pkg::REG_STAT: prdata = {16'h0000, state, plc_s,
					block_done, alarm};
				mst_pkg::REG_THR0: prdata = {16'h0000, thr0};
				mst_pkg::REG_THR1: prdata = {16'h0000, thr1};
				mst_pkg::REG_THR2: prdata = {16'h0000, thr2};
				mst_pkg::REG_MOUT: prdata = {16'h0000, decoded_byte,
					m_binary};
				mst_pkg::REG_IOUT: prdata = {13'h0000, gear_step,
					tool_word, gear_addr};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// m code map table: write {valid, index, bit} via REG_MMAP
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int i = 0; i < mst_pkg::MMAP_ENTRIES; i++) begin
				map_vld[i] <= 1'b0;
				map_idx[i] <= 7'h00;
			end
		end else if (wr && paddr == mst_pkg::REG_MMAP &&
				pwdata[14:8] < 7'd100) begin
			map_vld[pwdata[14:8]] <= pwdata[mst_pkg::MMAP_VALID];
			map_idx[pwdata[14:8]] <= {1'b0, pwdata[5:0]};
		end
	end

	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_cmd = cmd;
		next_thr0 = thr0;
		next_thr1 = thr1;
		next_thr2 = thr2;
		next_has_m = has_m;
		next_has_s = has_s;
		next_has_t = has_t;
		next_alarm = alarm;
		next_block_done = 1'b0;
		next_strobe = strobe;
		next_m_reg_bits = m_reg_bits;
		next_m_binary = m_binary;
		next_decoded = decoded_byte;
		next_gear_addr = gear_addr;
		next_gear_step = gear_step;
		next_tool_word = tool_word;
		if (wr) begin
			case (paddr)
				mst_pkg::REG_CTRL: next_ctrl = pwdata;
				mst_pkg::REG_THR0: next_thr0 = pwdata[15:0];
				mst_pkg::REG_THR1: next_thr1 = pwdata[15:0];
				mst_pkg::REG_THR2: next_thr2 = pwdata[15:0];
				default: next_ctrl = ctrl;
			endcase
		end
		if (plc_s.all_functions_done) begin
			next_decoded = 8'h00; // [RULE_22]
		end
		case (state)
			mst_pkg::ST_IDLE: begin
				// block accepted with its motion flag; functions run alongside
				if (wr && paddr == mst_pkg::REG_CMD &&
						!plc_s.all_functions_done) begin // [RULE_03]
					next_cmd = pwdata;
					next_has_m = pwdata[mst_pkg::CMD_HAS_M];
					next_has_s = pwdata[mst_pkg::CMD_HAS_S];
					next_has_t = pwdata[mst_pkg::CMD_HAS_T];
					next_state = mst_pkg::ST_M;
				end
			end
			mst_pkg::ST_M: begin
				next_state = mst_pkg::ST_S; // [RULE_04]
				if (has_m) begin
					if (mcode == mst_pkg::M_SUBCALL ||
							mcode == mst_pkg::M_SUBRET) begin
						next_has_m = 1'b0; // [RULE_18]
					end else if (mcode >= 7'd100 || !map_vld[mcode]) begin
						next_alarm = 1'b1; // [RULE_02]
						next_state = mst_pkg::ST_ALARM;
					end else begin
						next_m_reg_bits = 64'h0;
						next_m_reg_bits[map_idx[mcode][5:0]] = 1'b1;
						next_strobe.m_code_strobe = 1'b1; // [RULE_01]
						if (mcode <= mst_pkg::M_BIN_MAX) begin
							next_m_binary = {1'b0, mcode}; // [RULE_20]
						end
						// [RULE_19] [RULE_21]
						next_decoded = {mcode == mst_pkg::M_STOP,
							mcode == mst_pkg::M_OPT, mcode == mst_pkg::M_END,
							mcode == mst_pkg::M_REW, 4'h0};
					end
				end
			end
			mst_pkg::ST_S: begin
				next_state = mst_pkg::ST_T;
				if (has_s) begin
					if (ctrl[mst_pkg::CTRL_ANALOG]) begin // [RULE_09]
						next_gear_step = step_c;
						next_strobe.s_code_strobe = 1'b1; // [RULE_14]
					end else if (scode >= 16'h0001 && scode <= 16'h0008) begin
						next_gear_addr = 8'h01 << (scode[3:0] - 4'h1);
						next_strobe.s_code_strobe = 1'b1; // [RULE_10] [RULE_11]
					end else begin
						next_alarm = 1'b1; // [RULE_10]
						next_state = mst_pkg::ST_ALARM;
					end
				end
			end
			mst_pkg::ST_T: begin
				next_state = mst_pkg::ST_WAIT_DONE;
				if (has_t) begin
					next_tool_word = {4'h0, cmd[mst_pkg::CMD_T_LSB +: 4]};
					next_strobe.tool_code_strobe = 1'b1; // [RULE_16]
				end
				if (!has_m && !has_s && !has_t) begin
					next_block_done = 1'b1;
					next_state = mst_pkg::ST_IDLE;
				end
			end
			mst_pkg::ST_WAIT_DONE: begin
				if (plc_s.all_functions_done) begin // [RULE_05] [RULE_07]
					next_strobe = '0; // [RULE_23]
					next_m_reg_bits = 64'h0;
					next_m_binary = 8'h00;
					next_gear_addr = 8'h00;
					next_gear_step = 3'h0;
					next_tool_word = 8'h00;
					next_state = mst_pkg::ST_WAIT_LOW;
				end
			end
			mst_pkg::ST_WAIT_LOW: begin
				if (!plc_s.all_functions_done) begin // [RULE_23]
					next_block_done = 1'b1;
					next_state = mst_pkg::ST_IDLE;
				end
			end
			mst_pkg::ST_ALARM: begin
				next_strobe = '0;
				if (wr && paddr == mst_pkg::REG_CTRL &&
						pwdata[mst_pkg::CTRL_CLRALM]) begin
					next_alarm = 1'b0;
					next_ctrl[mst_pkg::CTRL_CLRALM] = 1'b0;
					next_state = mst_pkg::ST_IDLE;
				end
			end
			default: next_state = mst_pkg::ST_IDLE;
		endcase
		if (!clk_en) begin
			next_state = state;
			next_ctrl = ctrl;
			next_cmd = cmd;
			next_thr0 = thr0;
			next_thr1 = thr1;
			next_thr2 = thr2;
			next_has_m = has_m;
			next_has_s = has_s;
			next_has_t = has_t;
			next_alarm = alarm;
			next_block_done = block_done;
			next_strobe = strobe;
			next_m_reg_bits = m_reg_bits;
			next_m_binary = m_binary;
			next_decoded = decoded_byte;
			next_gear_addr = gear_addr;
			next_gear_step = gear_step;
			next_tool_word = tool_word;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= mst_pkg::ST_IDLE;
			ctrl <= mst_pkg::CTRL_RST;
			cmd <= 32'h0000_0000;
			thr0 <= mst_pkg::THR0_RST;
			thr1 <= mst_pkg::THR1_RST;
			thr2 <= mst_pkg::THR2_RST;
			has_m <= 1'b0;
			has_s <= 1'b0;
			has_t <= 1'b0;
			alarm <= 1'b0;
			block_done <= 1'b0;
			strobe <= '0;
			m_reg_bits <= 64'h0;
			m_binary <= 8'h00;
			decoded_byte <= 8'h00; // [RULE_22]
			gear_addr <= 8'h00;
			gear_step <= 3'h0;
			tool_word <= 8'h00;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			cmd <= next_cmd;
			thr0 <= next_thr0;
			thr1 <= next_thr1;
			thr2 <= next_thr2;
			has_m <= next_has_m;
			has_s <= next_has_s;
			has_t <= next_has_t;
			alarm <= next_alarm;
			block_done <= next_block_done;
			strobe <= next_strobe;
			m_reg_bits <= next_m_reg_bits;
			m_binary <= next_m_binary;
			decoded_byte <= next_decoded;
			gear_addr <= next_gear_addr;
			gear_step <= next_gear_step;
			tool_word <= next_tool_word;
		end
	end
endmodule : mst_function_handshake

// ---- verilog/mst_gear_step.sv ----
`timescale 1ns/1ps
module mst_gear_step (
	// speed and thresholds
	input wire logic [15:0] speed,
	input wire logic [15:0] thr0,
	input wire logic [15:0] thr1,
	input wire logic [15:0] thr2,
	// one-hot step
	output logic [2:0] step
);
	// lowest range whose threshold covers the speed; above thr2 -> top step, overriding thr0 and thr1
	always_comb begin
		if (speed <= thr0) begin
			step = 3'h1;
		end else if (speed <= thr1) begin
			step = 3'h2;
		end else begin
			step = 3'h4;
		end
		if (thr2 < speed) begin
			step = 3'h4;
		end
	end
endmodule : mst_gear_step

// ---- verilog/mst_sync.sv ----
`timescale 1ns/1ps
module mst_sync #(
	parameter int W = 7
) (
	// clocking
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = meta;
		next_q = q;
		if (!resetn) begin
			next_meta = '0;
			next_q = '0;
		end else if (clk_en) begin
			next_meta = d;
			next_q = meta;
		end
	end

	always_ff @(posedge ref_clk) begin
		meta <= next_meta;
		q <= next_q;
	end
endmodule : mst_sync
